// File: logic/drv_spi_core.sv
// Serial command port of an isolated gate driver: decode, registers, programming
// Function
// R1: 24 bits: write flag, address, data, check
// R2: temperature reads: four zeros, 12 bits, check
// R3: answer only with primary supply valid
// R4: CRC-8 poly 07, zero seed, MSB first
// R5: write check mismatch raises CRC fault
// R6: host sends and verifies correct check bytes
// R7: bad bit count aborts, posts both statuses; secondary status is posted only while the secondary is powered
// R8: non-multiple-of-24 clocks ignore all commands
// R9: ECC faults: correctable, fatal, primary posted
// R10: 011 applies values, 111 starts programming
// R11: busy bit high while programming runs
// R12: retry programming up to 40, then fail
// R13: silent until chip select first rises
// R14: no secondary power: discard writes, zero reads
// R15: input echoed on output 24 clocks later
// R16: chip select rise latches last 24 bits
// R17: response shifts out in next frame
// R18: output released while chip select high
// R19: host gives exactly 24 clocks per device
// R20: host sends reads to other chained devices
// R21: frames may follow without idle gaps
// R22: MSB first, sample rise, change fall
`timescale 1ns/1ps
`include "drv_spi_cfg.svh"
`default_nettype none

module drv_spi_core #(
   parameter int unsigned PROG_TIMEOUT_CYC = `PROG_TIME_MS * (`CLK_FREQ_HZ / 1000),
   parameter int TW = $clog2(PROG_TIMEOUT_CYC + 1)
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   input wire logic primary_undervoltage_lockout,
   input wire logic secondary_supply_ok,
   input wire logic [11:0] ext_temp_duty,
   input wire logic [11:0] die_temp_duty,
   input wire logic secondary_ecc_corrected,
   input wire logic secondary_ecc_uncorrectable,
   input wire logic primary_ecc_error,
   input wire logic nvm_program_done,
   input wire logic nvm_program_ok,
   output logic nvm_program_start,
   output logic simulate_apply,
   output logic shutdown
);

   ////////////////////////////////////////////////////////////////////////////
   // Types and state

   // All core state in one record
   typedef struct packed {
      logic [`SYNC_W-1:0] sync1;   // First stage, read by sync2 only
      logic [`SYNC_W-1:0] sync2;   // Settled pin and link levels
      logic cs_prev;               // Last settled chip select level
      logic tog_seen;              // Frame token already consumed
      logic armed;                 // Chip select has risen once
      logic respond;               // Serial output may drive
      drv_spi_pkg::core_state_e state;
      logic [23:0] cmd;            // Latched command frame
      logic [23:0] resp;           // Answer for the next frame
      logic [7:0] prim_status;     // Sticky primary-side faults
      logic [7:0] sec_status;      // Sticky secondary-side faults
      logic [1:0] sim_bits;        // Last written simulate bits
      drv_spi_pkg::prog_state_e pg_state;
      logic [5:0] tries;           // Programming attempts made
      logic [TW-1:0] pg_timer;     // Time spent programming
      logic prog_start;            // One-cycle start to the memory
      logic sim_apply;             // One-cycle apply pulse
      logic shutdown;              // Fatal fault latch
   } core_s;

   core_s q_q;
   core_s q_d;

   // Link side wires, quasi-static once chip select has risen
   logic [23:0] link_word;
   logic link_aligned;
   logic link_tog;

   // Memory port
   logic mem_we;
   logic [7:0] mem_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Check byte

   // R4: CRC-8, poly x^8+x^2+x+1, zero seed, MSB first
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = `CRC_SEED;
      for (int i = 15; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ `CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   // Frame with its own check byte appended
   function automatic logic [23:0] with_crc(input logic [15:0] p);
      return {p, crc8(p)};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Link and memory

   // Shifter on the serial clock
   spi_link #(
      .FB(`FRAME_BITS)
   ) u_link (
      .sclk(sclk),
      .cs_n(cs_n),
      .reset_n(reset_n),
      .mosi(mosi),
      .resp(q_q.resp),
      .enable(q_q.respond),
      .word(link_word),
      .aligned(link_aligned),
      .frame_tog(link_tog),
      .miso(miso),
      .miso_oe(miso_oe)
   );

   // Secondary configuration words, addressed by the low address bits
   reg_mem #(
      .AW(`SEC_MEM_AW),
      .DW(8)
   ) u_mem (
      .clk(clk),
      .reset_n(reset_n),
      .wr_en(mem_we),
      .wr_addr(q_q.cmd[`FRAME_ADDR_LSB +: `SEC_MEM_AW]),
      .wr_data(q_q.cmd[`FRAME_DATA_MSB:`FRAME_DATA_LSB]),
      .rd_addr(q_q.cmd[`FRAME_ADDR_LSB +: `SEC_MEM_AW]),
      .rd_data(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   // Decode, execute, answer and program in one pass
   always_comb begin
      logic cs_rise;
      logic uvlo;
      logic sec_ok;
      logic is_write;
      logic [6:0] addr;
      logic [7:0] data;
      logic sec_addr;
      logic crc_ok;
      logic prog_req;
      logic [7:0] rd_byte;
      logic [7:0] pset;
      logic [7:0] pclr;
      logic [7:0] sset;
      logic [7:0] sclr;
      cs_rise = 1'b0;
      uvlo = q_q.sync2[`SYNC_UVLO];
      sec_ok = q_q.sync2[`SYNC_SEC];
      // R1: field split of the latched frame
      is_write = q_q.cmd[`FRAME_RW_BIT];
      addr = q_q.cmd[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
      data = q_q.cmd[`FRAME_DATA_MSB:`FRAME_DATA_LSB];
      sec_addr = (addr >= `ADDR_SEC_BASE);
      crc_ok = (crc8(q_q.cmd[23:8]) == q_q.cmd[`FRAME_CRC_MSB:`FRAME_CRC_LSB]);
      prog_req = 1'b0;
      rd_byte = 8'h00;
      pset = 8'h00;
      pclr = 8'h00;
      sset = 8'h00;
      sclr = 8'h00;
      mem_we = 1'b0;
      q_d = q_q;
      q_d.prog_start = 1'b0;
      q_d.sim_apply = 1'b0;

      // Two flops for chip select, supplies and the frame token
      q_d.sync1 = {secondary_supply_ok, primary_undervoltage_lockout, link_tog, cs_n};
      q_d.sync2 = q_q.sync1;
      q_d.cs_prev = q_q.sync2[`SYNC_CS];
      cs_rise = q_q.sync2[`SYNC_CS] & ~q_q.cs_prev;

      // R3: no drive while the primary supply is locked out
      q_d.respond = q_q.armed & ~uvlo;

      case (q_q.state)
         drv_spi_pkg::ST_IDLE: begin
            if (cs_rise) begin
               // R13: first rise only arms the port
               q_d.armed = 1'b1;
               q_d.tog_seen = q_q.sync2[`SYNC_TOG];
               // A rise with no clocks at all carries nothing
               if (q_q.armed && !uvlo && (q_q.sync2[`SYNC_TOG] != q_q.tog_seen)) begin
                  if (link_aligned) begin
                     // R16: last frame of bits becomes the command
                     q_d.cmd = link_word;
                     q_d.state = drv_spi_pkg::ST_EXEC;
                  end else begin
                     // R7: wrong count aborts, posts to primary, and to secondary only when it is powered
                     // R8: command ignored entirely
                     pset[`PST_COMM_BIT] = 1'b1;
                     sset[`SST_COMM_BIT] = sec_ok;
                     q_d.resp = '0;
                  end
               end
            end
         end

         drv_spi_pkg::ST_EXEC: begin
            if (is_write) begin
               if (!crc_ok) begin
                  // R5: mismatching check byte, write dropped
                  pset[`PST_CRC_BIT] = 1'b1;
               end else if (sec_addr && !sec_ok) begin
                  // R14: secondary write without power is discarded
                  pset = 8'h00;
               end else if (addr == `ADDR_PRIM_STATUS) begin
                  // Ones written clear the matching faults
                  pclr = data;
               end else if (addr == `ADDR_SEC_STATUS) begin
                  sclr = data;
               end else if (addr == `ADDR_SEC_CTRL) begin
                  q_d.sim_bits = data[1:0];
                  // R10: only the exact patterns act
                  if (data[2:0] == `CTRL_SIMULATE) begin
                     q_d.sim_apply = 1'b1;
                  end else if (data[2:0] == `CTRL_PROGRAM) begin
                     prog_req = 1'b1;
                  end
               end else if (sec_addr) begin
                  mem_we = 1'b1;
               end
            end
            q_d.state = drv_spi_pkg::ST_READ;
         end

         drv_spi_pkg::ST_READ: begin
            // Memory read register settles after any write
            q_d.state = drv_spi_pkg::ST_BUILD;
         end

         default: begin
            // R17: answer prepared for the next chip select period
            if (addr == `ADDR_EXT_TEMP) begin
               // R2: four zero bits, 12-bit duty, check byte
               q_d.resp = with_crc({4'h0, ext_temp_duty});
            end else if (addr == `ADDR_DIE_TEMP) begin
               q_d.resp = with_crc({4'h0, die_temp_duty});
            end else if (sec_addr && !sec_ok) begin
               // R14: secondary read without power returns all zero
               q_d.resp = '0;
            end else begin
               if (addr == `ADDR_PRIM_STATUS) begin
                  rd_byte = q_q.prim_status;
               end else if (addr == `ADDR_SEC_CTRL) begin
                  // R11: busy bit visible while programming
                  rd_byte = {5'h00, q_q.pg_state != drv_spi_pkg::PG_IDLE, q_q.sim_bits};
               end else if (addr == `ADDR_SEC_STATUS) begin
                  rd_byte = q_q.sec_status;
               end else if (sec_addr) begin
                  rd_byte = mem_rdata;
               end
               q_d.resp = with_crc({is_write, addr, rd_byte});
            end
            q_d.state = drv_spi_pkg::ST_IDLE;
         end
      endcase

      // Programming sequence with retries and an overall time limit
      case (q_q.pg_state)
         drv_spi_pkg::PG_IDLE: begin
            if (prog_req) begin
               q_d.tries = '0;
               q_d.pg_timer = '0;
               q_d.pg_state = drv_spi_pkg::PG_START;
            end
         end

         drv_spi_pkg::PG_START: begin
            q_d.prog_start = 1'b1;
            q_d.tries = q_q.tries + 1'b1;
            q_d.pg_timer = q_q.pg_timer + 1'b1;
            q_d.pg_state = drv_spi_pkg::PG_WAIT;
         end

         default: begin
            q_d.pg_timer = q_q.pg_timer + 1'b1;
            if (nvm_program_done) begin
               if (nvm_program_ok) begin
                  // R11: busy drops when programming ends
                  q_d.pg_state = drv_spi_pkg::PG_IDLE;
               end else if (q_q.tries == 6'(`PROG_MAX_TRIES)) begin
                  // R12: out of attempts, abort and flag
                  sset[`SST_PFAIL_BIT] = 1'b1;
                  q_d.pg_state = drv_spi_pkg::PG_IDLE;
               end else begin
                  // R12: failed attempt repeats on its own
                  q_d.pg_state = drv_spi_pkg::PG_START;
               end
            end else if (q_q.pg_timer == TW'(PROG_TIMEOUT_CYC - 1)) begin
               // R11: time limit ends busy only if reached in PG_WAIT with no done that cycle
               sset[`SST_PFAIL_BIT] = 1'b1;
               q_d.pg_state = drv_spi_pkg::PG_IDLE;
            end
         end
      endcase

      // R9: ECC events, only the uncorrectable one stops the driver
      pset[`PST_ECC_BIT] = pset[`PST_ECC_BIT] | primary_ecc_error;
      sset[`SST_CORR_BIT] = secondary_ecc_corrected;
      sset[`SST_UNCORR_BIT] = secondary_ecc_uncorrectable;
      q_d.shutdown = q_q.shutdown | secondary_ecc_uncorrectable;

      // Sticky faults: a set in the clearing cycle survives
      q_d.prim_status = (q_q.prim_status & ~pclr) | pset;
      q_d.sec_status = (q_q.sec_status & ~sclr) | sset;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register

   // Chip select is taken as already high so power-up gives no false rise
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q_q <= '0;
         q_q.sync1[`SYNC_CS] <= 1'b1;
         q_q.sync2[`SYNC_CS] <= 1'b1;
         q_q.cs_prev <= 1'b1;
      end else begin
         q_q <= q_d;
      end
   end

   assign nvm_program_start = q_q.prog_start;
   assign simulate_apply = q_q.sim_apply;
   assign shutdown = q_q.shutdown;

endmodule

`default_nettype wire

// File: include/drv_spi_cfg.svh
// Constants of the isolated driver serial port: frame layout, map, fields, timing
`ifndef DRV_SPI_CFG_SVH
`define DRV_SPI_CFG_SVH

// Frame layout
`define FRAME_BITS 24
`define FRAME_RW_BIT 23
`define FRAME_ADDR_MSB 22
`define FRAME_ADDR_LSB 16
`define FRAME_DATA_MSB 15
`define FRAME_DATA_LSB 8
`define FRAME_CRC_MSB 7
`define FRAME_CRC_LSB 0
`define FRAME_CNT_W 5

// Check byte
`define CRC_POLY 8'h07
`define CRC_SEED 8'h00

// Register offsets
`define ADDR_PRIM_STATUS 7'h01
`define ADDR_EXT_TEMP 7'h08
`define ADDR_DIE_TEMP 7'h09
`define ADDR_SEC_BASE 7'h40
`define ADDR_SEC_CTRL 7'h42
`define ADDR_SEC_STATUS 7'h43
`define SEC_MEM_AW 6

// Secondary program control fields
`define CTRL_BUSY_BIT 2
`define CTRL_SIMULATE 3'h3
`define CTRL_PROGRAM 3'h7

// Primary status fields
`define PST_COMM_BIT 0
`define PST_CRC_BIT 1
`define PST_ECC_BIT 2

// Secondary status fields
`define SST_COMM_BIT 0
`define SST_CORR_BIT 1
`define SST_UNCORR_BIT 2
`define SST_PFAIL_BIT 3

// Synchroniser lanes
`define SYNC_W 4
`define SYNC_CS 0
`define SYNC_TOG 1
`define SYNC_UVLO 2
`define SYNC_SEC 3

// Programming timing
`define PROG_MAX_TRIES 40
`define PROG_TIME_MS 40
`define CLK_FREQ_HZ 100000000

`endif

// File: include/drv_spi_pkg.sv
// Types shared by the serial port of the isolated driver
package drv_spi_pkg;

   // Command execution sequence after chip select rises
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_READ,
      ST_BUILD
   } core_state_e;

   // Nonvolatile programming sequence
   typedef enum logic [1:0] {
      PG_IDLE,
      PG_START,
      PG_WAIT
   } prog_state_e;

endpackage

// File: logic/reg_mem.sv
// Small register memory for the secondary-side configuration space
`timescale 1ns/1ps
`include "drv_spi_cfg.svh"
`default_nettype none

module reg_mem #(
   parameter int AW = `SEC_MEM_AW,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);

   // Whole memory and its read register
   typedef struct packed {
      logic [2**AW-1:0][DW-1:0] mem;
      logic [DW-1:0] rd;
   } mem_s;

   mem_s q_q;
   mem_s q_d;

   // Write port and registered read
   always_comb begin
      q_d = q_q;
      if (wr_en) begin
         q_d.mem[wr_addr] = wr_data;
      end
      // Read sees the value stored before this edge's write
      q_d.rd = q_q.mem[rd_addr];
   end

   // Cleared so that unwritten words read as zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q_q <= '0;
      end else begin
         q_q <= q_d;
      end
   end

   assign rd_data = q_q.rd;

endmodule

`default_nettype wire

// File: logic/spi_link.sv
// Serial clock domain: input shifter, chain echo and response output
`timescale 1ns/1ps
`include "drv_spi_cfg.svh"
`default_nettype none

module spi_link #(
   parameter int FB = `FRAME_BITS
) (
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic reset_n,
   input wire logic mosi,
   input wire logic [FB-1:0] resp,
   input wire logic enable,
   output logic [FB-1:0] word,
   output logic aligned,
   output logic frame_tog,
   output logic miso,
   output logic miso_oe
);

   // State kept across frames
   typedef struct packed {
      logic [FB-1:0] shift;
      logic aligned;
      logic tog;
   } link_s;

   // State that ends with the frame
   typedef struct packed {
      logic [`FRAME_CNT_W-1:0] cnt;
      logic started;
   } frame_s;

   link_s l_q;
   link_s l_d;
   frame_s f_q;
   frame_s f_d;
   logic miso_q;
   logic out_started_q;

   // Rising edge: sample input, shift response out behind it
   always_comb begin
      l_d = l_q;
      f_d = f_q;
      // R15: response word first, then input delayed one frame
      if (!f_q.started) begin
         l_d.shift = {resp[FB-2:0], mosi};
         l_d.tog = ~l_q.tog;
      end else begin
         l_d.shift = {l_q.shift[FB-2:0], mosi};
      end
      // R8: frame boundary tracked modulo frame length
      l_d.aligned = (f_q.cnt == `FRAME_CNT_W'(FB - 1));
      f_d.cnt = l_d.aligned ? '0 : f_q.cnt + 1'b1;
      f_d.started = 1'b1;
   end

   // Kept after chip select rises so the core can read it
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         l_q <= '0;
      end else begin
         l_q <= l_d;
      end
   end

   // Bit count dies with the frame; the clock may stop at any time
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end

   // R22: output changes on the falling edge
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         miso_q <= 1'b0;
         out_started_q <= 1'b0;
      end else begin
         miso_q <= l_q.shift[FB-1];
         out_started_q <= 1'b1;
      end
   end

   // R17: first response bit stands from chip select fall
   assign miso = out_started_q ? miso_q : resp[FB-1];
   // R18: released whenever chip select is high
   assign miso_oe = ~cs_n & enable;
   // R16: last frame of input bits is the command
   assign word = l_q.shift;
   assign aligned = l_q.aligned;
   assign frame_tog = l_q.tog;

endmodule

`default_nettype wire

// File: tb/drv_spi_core_sva.sv
// Checker for the driver serial port
`timescale 1ns/1ps
`default_nettype none

module drv_spi_core_sva (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic primary_undervoltage_lockout,
   input wire logic secondary_ecc_uncorrectable,
   input wire logic nvm_program_done,
   input wire logic nvm_program_ok,
   input wire logic nvm_program_start,
   input wire logic simulate_apply,
   input wire logic shutdown
);
   ////////////////////////////////////////////////////////////
   // Link edges in this select period, saturating
   logic [5:0] bits_q;
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bits_q <= 6'h00;
      end else if (bits_q != 6'h3f) begin
         bits_q <= bits_q + 6'h01;
      end
   end
   // Attempts of the running programming sequence
   logic [5:0] tries_q;
   always_ff @(posedge clk) begin
      if (!reset_n || (nvm_program_done && (nvm_program_ok || tries_q == 6'h28))) begin
         tries_q <= 6'h00;
      end else if (nvm_program_start) begin
         tries_q <= tries_q + 6'h01;
      end
   end
   ////////////////////////////////////////////////////////////
   a_out_released: assert property (@(posedge clk) disable iff (!reset_n) cs_n |-> !miso_oe)
      else $error("output driven while deselected");
   a_echo_delay: assert property (@(posedge sclk) disable iff (!reset_n || cs_n)
      bits_q >= 6'h18 |-> miso == $past(mosi, 24)) else $error("chain echo not 24 edges late");
   a_lockout_mute: assert property (@(posedge clk) disable iff (!reset_n)
      primary_undervoltage_lockout [*4] |-> !miso_oe) else $error("answer under lockout");
   a_start_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      nvm_program_start |=> !nvm_program_start) else $error("start longer than one cycle");
   a_sim_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      simulate_apply |=> !simulate_apply) else $error("apply longer than one cycle");
   a_start_excl: assert property (@(posedge clk) disable iff (!reset_n)
      !(simulate_apply && nvm_program_start)) else $error("apply and program together");
   a_retry_gap: assert property (@(posedge clk) disable iff (!reset_n)
      nvm_program_done && !nvm_program_ok && tries_q < 6'h28 |-> ##2 nvm_program_start)
      else $error("failed attempt not retried");
   a_fail_stop: assert property (@(posedge clk) disable iff (!reset_n)
      nvm_program_done && !nvm_program_ok && tries_q == 6'h28 |=> !nvm_program_start [*8])
      else $error("retry after last attempt");
   a_shut_sticky: assert property (@(posedge clk) disable iff (!reset_n)
      shutdown |=> shutdown) else $error("shutdown dropped");
   a_uncorr_shut: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(secondary_ecc_uncorrectable) |-> ##[1:4] shutdown) else $error("no shutdown");
   // Main scenarios reached
   c_echo: cover property (@(posedge sclk) bits_q == 6'h30);
   c_fail: cover property (@(posedge clk) nvm_program_done && tries_q == 6'h28);
   c_sim: cover property (@(posedge clk) simulate_apply);
endmodule

bind drv_spi_core drv_spi_core_sva u_sva (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
   .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .primary_undervoltage_lockout(primary_undervoltage_lockout),
   .secondary_ecc_uncorrectable(secondary_ecc_uncorrectable), .nvm_program_done(nvm_program_done),
   .nvm_program_ok(nvm_program_ok), .nvm_program_start(nvm_program_start), .simulate_apply(simulate_apply),
   .shutdown(shutdown));
`default_nettype wire

// File: tb/spi_host_model.sv
// Serial host model: frames commands on the link and collects the answer
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   // Idle: clock low, select high, data at its pull-up level
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // One select period of n bits at a 6 ns link period
   // host-built frames, MSB first, no gaps, sample on rise
   task automatic xfer(input logic [47:0] c, input int n, output logic [47:0] r);
      r = 48'h0;
      #1.7 cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = c[i];
         #3 sclk = 1'b1;
         r[i] = miso;
         #3 sclk = 1'b0;
      end
      #3 cs_n = 1'b1;
      mosi = 1'b1;
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the isolated driver serial port
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic clk = 1'b0, lockout = 1'b0, sec_ok = 1'b1, ecc_c = 1'b0, ecc_u = 1'b0, ecc_p = 1'b0, done = 1'b0, ok = 1'b0;
   logic [11:0] ext_t = 12'h5a3, die_t = 12'ha5c;
   logic reset_n, sclk, cs_n, mosi, miso, miso_oe, start, sim, shut;
   logic [47:0] r;
   int n_errors = 0, num_checks = 0, cyc = 0, tries = 0, n_sim = 0, lat = 40, pass_at = 3;
   // Released output reads as z
   wire miso_line = miso_oe ? miso : 1'bz;

   always #5 clk = ~clk;

   drv_spi_core #(.PROG_TIMEOUT_CYC(4000)) dut (.clk(clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .primary_undervoltage_lockout(lockout),
      .secondary_supply_ok(sec_ok), .ext_temp_duty(ext_t), .die_temp_duty(die_t),
      .secondary_ecc_corrected(ecc_c), .secondary_ecc_uncorrectable(ecc_u), .primary_ecc_error(ecc_p),
      .nvm_program_done(done), .nvm_program_ok(ok), .nvm_program_start(start), .simulate_apply(sim),
      .shutdown(shut));
   spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_line));

   ////////////////////////////////////////////////////////////
   // Memory stand-in: attempts end lat cycles after start
   always @(posedge start) begin
      tries++;
      repeat (lat) @(negedge clk);
      ok = (tries == pass_at);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
   end
   // Apply pulses seen, and the hang guard
   always @(posedge clk) begin
      if (sim) n_sim++;
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Reference check byte
   function automatic logic [7:0] crc(input logic [15:0] d);
      crc = 8'h00;
      for (int i = 15; i >= 0; i--) crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ d[i]) ? 8'h07 : 8'h00);
   endfunction
   function automatic logic [23:0] frm(input logic w, input logic [6:0] a, input logic [7:0] d);
      frm = {w, a, d, crc({w, a, d})};
   endfunction
   // One frame, then a gap for the answer to be built
   task automatic go(input logic [23:0] c, input int n = 24);
      host.xfer({24'h0, c}, n, r);
      repeat (12) @(negedge clk);
   endtask
   // Read: the answer comes in the next select period
   task automatic rd(input logic [6:0] a);
      go(frm(1'b0, a, 8'h00));
      go(frm(1'b0, 7'h00, 8'h00));
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_basic;
      go(frm(1'b1, 7'h45, 8'h3c));
      chk(r[23:0], 24'hzzzzzz);
      go(frm(1'b1, 7'h45, 8'h3c));
      rd(7'h45);
      chk(r[23:0], frm(1'b0, 7'h45, 8'h3c));
      go(frm(1'b1, 7'h45, 8'hc3) ^ 24'h1);
      rd(7'h45);
      chk(r[23:0], frm(1'b0, 7'h45, 8'h3c));
      rd(7'h01);
      chk(24'(r[9]), 24'h1);
      rd(7'h08);
      chk(r[23:0], {4'h0, ext_t, crc({4'h0, ext_t})});
      rd(7'h09);
      chk(r[23:0], {4'h0, die_t, crc({4'h0, die_t})});
      $display("t_basic done");
   endtask
   task automatic t_count;
      go(frm(1'b1, 7'h46, 8'h77));
      go(frm(1'b1, 7'h46, 8'h11), 25);
      go(frm(1'b1, 7'h46, 8'h22), 23);
      rd(7'h46);
      chk(r[23:0], frm(1'b0, 7'h46, 8'h77));
      rd(7'h01);
      chk(24'(r[8]), 24'h1);
      rd(7'h43);
      chk(24'(r[8]), 24'h1);
      host.xfer({frm(1'b1, 7'h47, 8'h5a), frm(1'b0, 7'h45, 8'h00)}, 48, r);
      chk(r[23:0], frm(1'b1, 7'h47, 8'h5a));
      repeat (12) @(negedge clk);
      go(frm(1'b0, 7'h00, 8'h00));
      chk(r[23:0], frm(1'b0, 7'h45, 8'h3c));
      $display("t_count done");
   endtask
   task automatic t_supply;
      sec_ok = 1'b0;
      repeat (4) @(negedge clk);
      go(frm(1'b1, 7'h45, 8'h99));
      rd(7'h45);
      chk(r[23:0], 24'h0);
      sec_ok = 1'b1;
      lockout = 1'b1;
      repeat (4) @(negedge clk);
      go(frm(1'b1, 7'h45, 8'h66));
      chk(r[23:0], 24'hzzzzzz);
      lockout = 1'b0;
      repeat (4) @(negedge clk);
      rd(7'h45);
      chk(r[23:0], frm(1'b0, 7'h45, 8'h3c));
      $display("t_supply done");
   endtask
   task automatic t_prog;
      go(frm(1'b1, 7'h42, 8'h03));
      go(frm(1'b1, 7'h42, 8'h05));
      chk(24'(n_sim), 24'h1);
      chk(24'(tries), 24'h0);
      go(frm(1'b1, 7'h42, 8'h07));
      rd(7'h42);
      chk(24'(r[10]), 24'h1);
      repeat (200) @(negedge clk);
      rd(7'h42);
      chk(24'(r[10]), 24'h0);
      chk(24'(tries), 24'h3);
      pass_at = 99;
      go(frm(1'b1, 7'h42, 8'h07));
      repeat (2000) @(negedge clk);
      chk(24'(tries), 24'h2b);
      rd(7'h43);
      chk(24'(r[11]), 24'h1);
      $display("t_prog done");
   endtask
   task automatic t_ecc;
      ecc_c = 1'b1;
      ecc_p = 1'b1;
      @(negedge clk);
      ecc_c = 1'b0;
      ecc_p = 1'b0;
      rd(7'h43);
      chk(24'(r[9]), 24'h1);
      rd(7'h01);
      chk(24'(r[10]), 24'h1);
      chk(24'(shut), 24'h0);
      go(frm(1'b1, 7'h01, 8'h04));
      rd(7'h01);
      chk(24'(r[10]), 24'h0);
      ecc_u = 1'b1;
      @(negedge clk);
      ecc_u = 1'b0;
      repeat (6) @(negedge clk);
      chk(24'(shut), 24'h1);
      $display("t_ecc done");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Reset falls after time zero so async clears see an edge
   initial begin
      #1 reset_n = 1'b0;
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      t_basic();
      t_count();
      t_supply();
      t_prog();
      t_ecc();
      tally_and_finish();
   end
endmodule
`default_nettype wire
